// ===== rtc_rw_pkg.sv
// constants and types shared by the recovery / watch / clock-out block
package rtc_rw_pkg;
  // register map
  localparam logic [7:0] ADDR_CTRL1    = 8'h00;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h01;
  localparam logic [7:0] ADDR_IRQ_FLAG = 8'h02;
  localparam logic [7:0] ADDR_STATUS   = 8'h03;
  localparam logic [7:0] ADDR_CTRL_RST = 8'h04;
  localparam logic [7:0] ADDR_PCFG     = 8'h30;
  // field positions
  localparam int CTRL1_RUN_BIT   = 0;
  localparam int CTRL1_REC_BIT   = 4;
  localparam int CTRL1_CLKSEL_BIT = 7;
  localparam int SYSRST_BIT      = 4;
  localparam int VLOW1_BIT       = 2;
  localparam int VLOW2_BIT       = 3;
  localparam int CTRL_RST_BIT    = 4;
  localparam int PCFG_SCAN_BIT   = 0;
  localparam int PCFG_FSEL_LO    = 2;
  localparam int PCFG_FSEL_HI    = 3;
  localparam int NUM_SRC         = 4;
  // reset values and implemented-bit masks
  localparam logic [7:0] CTRL1_RST   = 8'h91;
  localparam logic [7:0] IRQ_EN_RST  = 8'h00;
  localparam logic [7:0] PCFG_RST    = 8'h00;
  localparam logic [7:0] ZERO8       = 8'h00;
  localparam logic [7:0] IRQ_MASK    = 8'h1f;
  localparam logic [7:0] STATUS_MASK = 8'h1c;
  // prescaler: 15-bit divider of the 32.768 kHz oscillator
  localparam int PRESC_W  = 15;
  localparam int TAP_1024 = 4;
  localparam int TAP_32   = 9;
  localparam int TAP_1    = 14;
  // watchdog: two scan intervals, counted in 1 Hz ticks
  localparam int WD_W          = 6;
  localparam int SCAN_SHORT_S  = 1;
  localparam int SCAN_LONG_S   = 16;
  localparam int WD_INTERVALS  = 2;
  localparam logic [WD_W-1:0] WD_LIMIT_SHORT =
    WD_W'(WD_INTERVALS * SCAN_SHORT_S);
  localparam logic [WD_W-1:0] WD_LIMIT_LONG =
    WD_W'(WD_INTERVALS * SCAN_LONG_S);
  // output frequency select codes
  typedef enum logic [1:0] {
    FREQ_32K  = 2'b00,
    FREQ_1024 = 2'b01,
    FREQ_32   = 2'b10,
    FREQ_1    = 2'b11
  } out_freq_t;
endpackage

// ===== tick_bus_if.sv
// tick and watchdog signals between the core and its helpers
`timescale 1ns/1ns
interface tick_bus_if;
  logic osc_tick;
  logic comp_add;
  logic comp_skip;
  logic sec_tick;
  logic tap_1024;
  logic tap_32;
  logic tap_1;
  logic wd_enable;
  logic scan_sel;
  logic restart;
  logic timeout;
  modport presc (input osc_tick, comp_add, comp_skip,
                 output sec_tick, tap_1024, tap_32, tap_1);
  modport wdog  (input sec_tick, wd_enable, scan_sel, restart,
                 output timeout);
  modport core  (output osc_tick, comp_add, comp_skip, wd_enable,
                 scan_sel, restart,
                 input sec_tick, tap_1024, tap_32, tap_1, timeout);
endinterface

// ===== osc_prescaler.sv
// compensated oscillator prescaler with clock-out taps and 1 Hz tick
`timescale 1ns/1ns
module osc_prescaler
  import rtc_rw_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rstn,
  tick_bus_if.presc tb
);
  logic [PRESC_W-1:0] cnt_r;
  logic [PRESC_W:0]   sum;
  logic [1:0]         inc;
  logic               tick_r;

  // compensation adds or swallows one count per event
  always_comb begin
    inc = 2'h0;
    if (tb.osc_tick && !tb.comp_skip)
      inc = tb.comp_add ? 2'h2 : 2'h1;
    else if (!tb.osc_tick && tb.comp_add)
      inc = 2'h1;
    sum = {1'b0, cnt_r} + {{(PRESC_W-1){1'b0}}, inc};
  end

  // divider chain; carry out of the top is the second tick
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= sum[PRESC_W-1:0];
      tick_r <= sum[PRESC_W];
    end
  end

  // binary taps give exact 50:50 duty
  assign tb.tap_1024 = cnt_r[TAP_1024];
  assign tb.tap_32   = cnt_r[TAP_32];
  assign tb.tap_1    = cnt_r[TAP_1];
  assign tb.sec_tick = tick_r;
endmodule

// ===== recovery_watchdog.sv
// self-recovery watchdog counting 1 Hz ticks since the last restart
`timescale 1ns/1ns
module recovery_watchdog
  import rtc_rw_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_rstn,
  tick_bus_if.wdog  tb
);
  logic [WD_W-1:0] cnt_r;
  logic [WD_W-1:0] limit;
  logic            to_r;

  // two scan intervals: 1 s base or 16 s base
  assign limit = tb.scan_sel ? WD_LIMIT_LONG : WD_LIMIT_SHORT;

  // restart or disable clears; reaching the limit fires once
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt_r <= '0;
      to_r  <= 1'b0;
    end else begin
      to_r <= 1'b0;
      if (tb.restart || !tb.wd_enable || to_r) begin
        cnt_r <= '0;
      end else if (tb.sec_tick) begin
        if (cnt_r + 1'b1 >= limit)
          to_r <= 1'b1;
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign tb.timeout = to_r;
endmodule

// ===== rtc_recovery_watch_square_wave_out.sv
// control registers, reset recovery, watch gate and clock output
`timescale 1ns/1ns
module rtc_recovery_watch_square_wave_out
  import rtc_rw_pkg::*;
(
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire logic [7:0]         i_reg_addr,
  input  wire logic [7:0]         i_reg_wdata,
  input  wire logic               i_reg_wr,
  input  wire logic               i_reg_rd,
  output logic      [7:0]         o_reg_rdata,
  input  wire logic               i_osc_tick,
  input  wire logic               i_osc_level,
  input  wire logic               i_comp_add,
  input  wire logic               i_comp_skip,
  input  wire logic               i_wd_kick,
  input  wire logic [NUM_SRC-1:0] i_irq_src,
  input  wire logic [1:0]         i_vlow_set,
  input  wire logic               i_square_out_enable_pin,
  output logic                    o_time_tick,
  output logic                    o_watch_run,
  output logic                    o_sysrst_pulse,
  output logic                    o_int_o,
  output logic                    o_int_oe,
  output logic                    o_square_wave_out
);
  tick_bus_if tb ();

  logic [7:0] ctrl1_r;
  logic [7:0] irq_en_r;
  logic [7:0] irq_flag_r;
  logic [7:0] status_r;
  logic [7:0] pcfg_r;
  logic [7:0] flag_set;
  logic [7:0] stat_set;
  logic [7:0] int_src;
  logic       wr_ctrl1;
  logic       wr_irq_en;
  logic       wr_flag;
  logic       wr_status;
  logic       wr_pcfg;
  logic       sw_sysrst;
  logic       soft_rst;
  logic       recovered;
  logic       tick_r;
  logic       rst_pulse_r;
  logic       int_r;
  logic       sq_r;
  logic       sq_sel;
  out_freq_t  fsel;

  //////////////////////////////////////////////////////////////////////
  // helpers

  osc_prescaler u_presc (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .tb     (tb.presc)
  );

  recovery_watchdog u_wdog (
    .i_clk  (i_clk),
    .i_rstn (i_rstn),
    .tb     (tb.wdog)
  );

  // the watchdog only sees seconds from the prescaler, so a stalled
  // oscillator also stalls recovery; the control logic kick and any
  // internal reset both restart it, and the reset it issues clears it
  // again, which keeps a single expiry from firing twice
  // drive the core side of the tick bus
  assign tb.osc_tick  = i_osc_tick;
  assign tb.comp_add  = i_comp_add;
  assign tb.comp_skip = i_comp_skip;
  assign tb.wd_enable = ctrl1_r[CTRL1_REC_BIT];
  assign tb.scan_sel  = pcfg_r[PCFG_SCAN_BIT];
  assign tb.restart   = i_wd_kick | soft_rst;

  //////////////////////////////////////////////////////////////////////
  // register write decode

  // register map, one byte per address:
  //   0x00 control: run bit 0, recovery enable bit 4, clock select bit 7
  //   0x01 interrupt enables, bits 4:0
  //   0x02 interrupt flags, bits 4:0, write zero clears, one keeps
  //   0x03 status: low-voltage bits 2 and 3, reset cause bit 4
  //   0x04 reset command, bit 4 set starts an internal reset
  //   0x30 persistent config: scan select bit 0, frequency bits 3:2
  // unmapped writes are dropped and unmapped reads return zero
  // strobes are single-cycle, so no write can be taken twice
  // the serial interface delivers already-decoded register accesses
  assign wr_ctrl1  = i_reg_wr && (i_reg_addr == ADDR_CTRL1);
  assign wr_irq_en = i_reg_wr && (i_reg_addr == ADDR_IRQ_EN);
  assign wr_flag   = i_reg_wr && (i_reg_addr == ADDR_IRQ_FLAG);
  assign wr_status = i_reg_wr && (i_reg_addr == ADDR_STATUS);
  assign wr_pcfg   = i_reg_wr && (i_reg_addr == ADDR_PCFG);
  assign sw_sysrst = i_reg_wr && (i_reg_addr == ADDR_CTRL_RST) &&
                     i_reg_wdata[CTRL_RST_BIT];

  // watchdog expiry issues the internal reset
  assign recovered = tb.timeout;
  assign soft_rst  = recovered | sw_sysrst;

  // hardware set sources for flag and status bits
  always_comb begin
    flag_set = ZERO8;
    stat_set = ZERO8;
    flag_set[NUM_SRC-1:0] = i_irq_src;
    flag_set[SYSRST_BIT]  = recovered;
    stat_set[VLOW1_BIT]   = i_vlow_set[0];
    stat_set[VLOW2_BIT]   = i_vlow_set[1];
    stat_set[SYSRST_BIT]  = soft_rst;
  end

  //////////////////////////////////////////////////////////////////////
  // control registers

  // power-up and internal reset share one reload image; the
  // persistent config below is deliberately outside it
  // power-up sets run, recovery enable and clock select
  // internal reset reloads control, persistent config kept
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl1_r  <= CTRL1_RST;
      irq_en_r <= IRQ_EN_RST;
    end else if (soft_rst) begin
      ctrl1_r  <= CTRL1_RST;
      irq_en_r <= IRQ_EN_RST;
    end else begin
      if (wr_ctrl1)
        ctrl1_r <= i_reg_wdata;
      if (wr_irq_en)
        irq_en_r <= i_reg_wdata & IRQ_MASK;
    end
  end

  // persistent configuration survives internal resets
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      pcfg_r <= PCFG_RST;
    else if (wr_pcfg)
      pcfg_r <= i_reg_wdata;
  end

  // flag and status bits are sticky: hardware sets them and a
  // zero written by the host clears them; an internal reset clears
  // all of them except what that reset and same-cycle events record, so the host can
  // always read back why the logic restarted
  // flags clear by writing zero or by an internal reset
  // set wins over a clear arriving in the same cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_flag_r <= ZERO8;
      status_r   <= ZERO8;
    end else if (soft_rst) begin
      // flag set in the same cycle as the reload of the other flags
      irq_flag_r <= flag_set & IRQ_MASK;
      status_r   <= stat_set & STATUS_MASK;
    end else begin
      irq_flag_r <= ((wr_flag ? irq_flag_r & i_reg_wdata : irq_flag_r)
                     | flag_set) & IRQ_MASK;
      status_r   <= ((wr_status ? status_r & i_reg_wdata : status_r)
                     | stat_set) & STATUS_MASK;
    end
  end

  // read-back path so the host learns the reset cause
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_reg_rdata <= ZERO8;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        ADDR_CTRL1:    o_reg_rdata <= ctrl1_r;
        ADDR_IRQ_EN:   o_reg_rdata <= irq_en_r;
        ADDR_IRQ_FLAG: o_reg_rdata <= irq_flag_r;
        ADDR_STATUS:   o_reg_rdata <= status_r;
        ADDR_PCFG:     o_reg_rdata <= pcfg_r;
        default:       o_reg_rdata <= ZERO8;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // watch tick

  // the time counters live outside this block; only their advance
  // pulse is gated here, so a stopped watch keeps its value and may
  // be loaded; a restart is aligned to the prescaler, not to the
  // write, so the first second after it may be short
  // run bit gates the tick
  // counters hold while the bit is zero
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      tick_r <= 1'b0;
    else
      tick_r <= tb.sec_tick & ctrl1_r[CTRL1_RUN_BIT];
  end

  assign o_time_tick = tick_r;
  assign o_watch_run = ctrl1_r[CTRL1_RUN_BIT];

  // internal reset pulse to the rest of the chip; time is left alone
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      rst_pulse_r <= 1'b0;
    else
      rst_pulse_r <= soft_rst;
  end

  assign o_sysrst_pulse = rst_pulse_r;

  //////////////////////////////////////////////////////////////////////
  // interrupt pin

  // sources per bit: 0 alarm, 1 timer, 2 and 3 low voltage, 4 reset
  // for bits 2 to 4 the status copy keeps the source alive, so the
  // host must clear both the flag and the status bit to release the
  // pin; a new event in the clearing cycle still wins
  // alarm and timer sources from their own flag only
  // system reset source follows its flag or its status bit
  // held until status bit cleared too
  always_comb begin
    int_src = irq_flag_r & irq_en_r;
    int_src[VLOW1_BIT]  = irq_en_r[VLOW1_BIT] &
                          (irq_flag_r[VLOW1_BIT] | status_r[VLOW1_BIT]);
    int_src[VLOW2_BIT]  = irq_en_r[VLOW2_BIT] &
                          (irq_flag_r[VLOW2_BIT] | status_r[VLOW2_BIT]);
    int_src[SYSRST_BIT] = irq_en_r[SYSRST_BIT] &
                          (irq_flag_r[SYSRST_BIT] | status_r[SYSRST_BIT]);
  end

  // open drain, driven low only when asserted
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      int_r <= 1'b0;
    else
      int_r <= |int_src;
  end

  assign o_int_o  = 1'b0;
  assign o_int_oe = int_r;

  //////////////////////////////////////////////////////////////////////
  // square-wave clock output

  // output frequency choices:
  //   00 raw oscillator level, uncompensated, duty left to the crystal
  //   01 prescaler bit for 1024 Hz, compensated
  //   10 prescaler bit for 32 Hz, compensated
  //   11 prescaler bit for 1 Hz, compensated
  // the registered pin adds one cycle of lag to every choice, which
  // is harmless against periods of many cycles
  assign fsel = out_freq_t'(pcfg_r[PCFG_FSEL_HI:PCFG_FSEL_LO]);

  // raw oscillator versus compensated prescaler taps
  always_comb begin
    unique case (fsel)
      FREQ_32K:  sq_sel = i_osc_level;
      FREQ_1024: sq_sel = tb.tap_1024;
      FREQ_32:   sq_sel = tb.tap_32;
      FREQ_1:    sq_sel = tb.tap_1;
    endcase
  end

  // run bit deliberately absent from this path
  // select bit gates a push-pull output
  // select zero holds the pin low
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn)
      sq_r <= 1'b0;
    else
      sq_r <= sq_sel & ctrl1_r[CTRL1_CLKSEL_BIT] &
              i_square_out_enable_pin;
  end

  assign o_square_wave_out = sq_r;
endmodule

// ===== rtc_rw_monitor.sv
// assertion checker for the recovery, watch and clock-out block
`timescale 1ns/1ns
module rtc_rw_monitor
  import rtc_rw_pkg::*;
(
  input wire logic               i_clk,
  input wire logic               i_rstn,
  input wire logic               i_reg_wr,
  input wire logic [NUM_SRC-1:0] i_irq_src,
  input wire logic [1:0]         i_vlow_set,
  input wire logic               i_square_out_enable_pin,
  input wire logic               o_time_tick,
  input wire logic               o_watch_run,
  input wire logic               o_sysrst_pulse,
  input wire logic               o_int_o,
  input wire logic               o_int_oe,
  input wire logic               o_square_wave_out
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // anything allowed to raise the interrupt two edges later
  logic any_cause;
  assign any_cause = (|i_irq_src) | (|i_vlow_set) | i_reg_wr;

  ////////////////////////////////////////////////////////////////////////////
  // named steps, a registered output lags its cause by one edge
  sequence s_pin_low;
    !i_square_out_enable_pin;
  endsequence
  sequence s_out_low;
    !o_square_wave_out;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // open-drain data
  AST_INT_DRAIN: assert property (o_int_o == 1'b0)
    else $error("interrupt data not low");
  AST_PIN_LOW: assert property (s_pin_low |=> s_out_low)
    else $error("clock out high with enable pin low");
  AST_RUN_GATE: assert property (
    o_time_tick |-> o_watch_run || $past(o_watch_run))
    else $error("tick while watch stopped");
  AST_TICK_SPACE: assert property (
    o_time_tick |=> !o_time_tick [*8])
    else $error("time tick repeats too soon");
  AST_SYSRST_ONE: assert property (
    o_sysrst_pulse |=> !o_sysrst_pulse)
    else $error("reset pulse longer than a cycle");
  AST_RELOAD: assert property (
    o_sysrst_pulse |-> ##[0:1] o_watch_run)
    else $error("run bit not reloaded by internal reset");
  AST_INT_RISE: assert property (
    $rose(o_int_oe) |-> $past(any_cause, 2))
    else $error("interrupt rose without cause");
  // fall needs a clear, or the internal reset pulse a cycle earlier
  AST_INT_FALL: assert property (
    $fell(o_int_oe) |-> $past(i_reg_wr, 2) || $past(o_sysrst_pulse))
    else $error("interrupt fell without clear");
endmodule

bind rtc_recovery_watch_square_wave_out rtc_rw_monitor mon (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_reg_wr(i_reg_wr),
  .i_irq_src(i_irq_src), .i_vlow_set(i_vlow_set),
  .i_square_out_enable_pin(i_square_out_enable_pin),
  .o_time_tick(o_time_tick), .o_watch_run(o_watch_run),
  .o_sysrst_pulse(o_sysrst_pulse), .o_int_o(o_int_o),
  .o_int_oe(o_int_oe), .o_square_wave_out(o_square_wave_out));

// ===== host_model.sv
// host side of the register port: byte writes and reads
`timescale 1ns/1ns
module host_model (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  // idle bus at time zero
  initial begin
    o_addr  = 8'h00;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_wdata <= ~d; // stale data is never left on a released bus
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
    @(posedge i_clk);
    d = i_rdata;
  endtask
endmodule

// ===== testbench.sv
// self-checking bench for the recovery, watch and clock-out block
`timescale 1ns/1ns
module testbench
  import rtc_rw_pkg::*;
;
  typedef struct packed {logic [7:0] addr; logic [7:0] exp;} row_t;
  logic       i_clk = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] addr, wdata, rdata, rd_val;
  logic       wr, rd, osc_level = 1'b0, wd_kick = 1'b0, oe_pin = 1'b1;
  logic [3:0] irq_src = 4'h0;
  logic [1:0] vlow_set = 2'b00;
  logic       comp_add = 1'b0, comp_skip = 1'b0;
  logic       time_tick, watch_run, sysrst, int_o, int_oe, sq_out;
  int         num_errors = 0;
  int         num_checks = 0;
  // reset image, image after self-recovery from row 7, after the
  // software reset command from row 12
  row_t rows [15] = '{'{8'h00,8'h91}, '{8'h01,8'h00}, '{8'h02,8'h00},
    '{8'h03,8'h00}, '{8'h04,8'h00}, '{8'h30,8'h00}, '{8'h10,8'h00},
    '{8'h00,8'h91}, '{8'h01,8'h00}, '{8'h02,8'h10}, '{8'h03,8'h10},
    '{8'h30,8'hfc}, '{8'h00,8'h91}, '{8'h02,8'h00}, '{8'h03,8'h10}};

  always #25 i_clk = ~i_clk;

  host_model host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr),
    .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  // oscillator ticks every clock so a second is 32768 cycles
  rtc_recovery_watch_square_wave_out uut (.i_clk(i_clk), .i_rstn(rstn),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
    .o_reg_rdata(rdata), .i_osc_tick(1'b1), .i_osc_level(osc_level),
    .i_comp_add(comp_add), .i_comp_skip(comp_skip), .i_wd_kick(wd_kick),
    .i_irq_src(irq_src), .i_vlow_set(vlow_set),
    .i_square_out_enable_pin(oe_pin), .o_time_tick(time_tick),
    .o_watch_run(watch_run), .o_sysrst_pulse(sysrst), .o_int_o(int_o),
    .o_int_oe(int_oe), .o_square_wave_out(sq_out));

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic bail;
    num_errors++;
    $display("BAD %0t wait ran out", $time);
    report_and_stop();
  endtask
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t byte %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t bit %b expected %b", $time, g, e);
    end
  endtask
  task automatic chk_cnt(input int g, input int e);
    num_checks++;
    if (g != e) begin
      num_errors++;
      $display("BAD %0t count %0d expected %0d", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wait_lvl(input logic v);
    int n;
    for (n = 0; n < 2000 && sq_out !== v; n++) @(posedge i_clk);
    if (n == 2000) bail();
  endtask
  // high time of one full period of the clock output
  task automatic hi_run(output int n);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    for (n = 0; n < 2000 && sq_out === 1'b1; n++) @(posedge i_clk);
    if (n == 2000) bail();
  endtask
  task automatic ones(output int c);
    tick(2);
    c = 0;
    repeat (40) begin
      @(posedge i_clk);
      c += (sq_out === 1'b1);
    end
  endtask
  task automatic int_seq(input logic [7:0] en);
    host.wr(ADDR_IRQ_EN, en);
    tick(3);
    chk_bit(int_oe, 1'b1);
    host.wr(ADDR_IRQ_FLAG, 8'h00);
    tick(3);
    chk_bit(int_oe, 1'b1);
    host.wr(ADDR_STATUS, 8'h00);
    tick(3);
    chk_bit(int_oe, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int i, n, c, ticks, run, hi;
    repeat (3) @(posedge i_clk);
    rstn <= 1'b1;
    for (i = 0; i < 7; i++) begin
      host.rd(rows[i].addr, rd_val);
      chk_byte(rd_val, rows[i].exp);
    end
    // stopped watch, recovery off, clock output still running
    host.wr(ADDR_CTRL1, 8'h80);
    tick(1);
    chk_bit(watch_run, 1'b0);
    host.wr(ADDR_PCFG, 8'hf4);
    host.rd(ADDR_PCFG, rd_val);
    chk_byte(rd_val, 8'hf4);
    hi_run(c);
    chk_cnt(c, 16);
    // compensation reaches the divided taps: add doubles, skip freezes
    comp_add <= 1'b1;
    hi_run(c);
    chk_cnt(c, 8);
    comp_add <= 1'b0;
    wait_lvl(1'b1);
    comp_skip <= 1'b1;
    ones(c);
    chk_cnt(c, 40);
    comp_skip <= 1'b0;
    host.wr(ADDR_PCFG, 8'hf8);
    hi_run(c);
    chk_cnt(c, 512);
    host.wr(ADDR_PCFG, 8'hf0);
    osc_level <= 1'b1;
    tick(3);
    chk_bit(sq_out, 1'b1);
    osc_level <= 1'b0;
    tick(3);
    chk_bit(sq_out, 1'b0);
    host.wr(ADDR_PCFG, 8'hf4);
    oe_pin <= 1'b0;
    ones(c);
    chk_cnt(c, 0);
    oe_pin <= 1'b1;
    host.wr(ADDR_CTRL1, 8'h00);
    ones(c);
    chk_cnt(c, 0);
    // alarm and low-voltage sources, the latter sets status only, no flag
    @(posedge i_clk);
    irq_src <= 4'h1;
    vlow_set <= 2'b01;
    @(posedge i_clk);
    irq_src <= 4'h0;
    vlow_set <= 2'b00;
    int_seq(8'h05);
    chk_bit(int_o, 1'b0);
    // watch stopped and never kicked again: recovery must fire
    host.wr(ADDR_PCFG, 8'hfc);
    host.wr(ADDR_IRQ_EN, 8'h1f);
    host.wr(ADDR_CTRL1, 8'h90);
    @(posedge i_clk);
    wd_kick <= 1'b1;
    @(posedge i_clk);
    wd_kick <= 1'b0;
    ticks = 0;
    run = 0;
    hi = 0;
    for (n = 0; n < 70000 && sysrst !== 1'b1; n++) begin
      @(posedge i_clk);
      ticks += (time_tick === 1'b1);
      if (sq_out === 1'b1) run++;
      else begin
        if (run > 0) hi = run;
        run = 0;
      end
    end
    if (n == 70000) bail();
    chk_cnt(ticks, 0);
    chk_cnt(hi, 16384);
    tick(2);
    chk_bit(watch_run, 1'b1);
    for (i = 7; i < 12; i++) begin
      host.rd(rows[i].addr, rd_val);
      chk_byte(rd_val, rows[i].exp);
    end
    int_seq(8'h10);
    // software reset command: reload, status bit only, one pulse
    host.wr(ADDR_CTRL1, 8'h80);
    host.wr(ADDR_CTRL_RST, 8'h10);
    @(posedge i_clk);
    chk_bit(sysrst, 1'b1);
    for (i = 12; i < 15; i++) begin
      host.rd(rows[i].addr, rd_val);
      chk_byte(rd_val, rows[i].exp);
    end
    for (n = 0; n < 34000 && time_tick !== 1'b1; n++) @(posedge i_clk);
    if (n == 34000) bail();
    chk_bit(time_tick, 1'b1);
    report_and_stop();
  end
endmodule
